// *** rtl/tpf_test_pattern_frame_clock.sv ***
// Test pattern generator and frame clock setup ahead of the bit mapper.
// Assumes converter samples arrive on clk_sys and that the serial
// control port pins are asynchronous and much slower than clk_sys.
//
// Summary of operation
// - Constant mode sends the 18-bit custom value instead of converter data.
// - Ramp mode adds the custom value to the ramp every sample.
// - Bits 7..5 of the upper pattern register select channel B source.
// - Bits 4..2 select channel A source, reset value 000.
// - Codes 000 normal, 010 ramp, 011 constant; others unused.
// - Pattern is inserted before the bit mapper, MSB aligned, 18 bits.
// - Pattern generation is the same for every output format.
// - Frame clock register bit 7 picks core or downconverter frame clock.
// - Stretch bit makes one frame span channel A and B samples.
`timescale 1ns/10ps
module tpf_test_pattern_frame_clock
    import tpf_pkg::*;
(
    input  wire logic                clk_sys,
    input  wire logic                rst,
    // Serial control port
    input  wire logic                spi_sclk,
    input  wire logic                spi_sen_n,
    input  wire logic                spi_sdin,
    output logic                     spi_sdout,
    output logic                     spi_sdout_oe,
    // Converter core samples
    input  wire logic                adc_valid,
    output logic                     adc_ready,
    input  wire logic [SAMPLE_W-1:0] adc_data_a,
    input  wire logic [SAMPLE_W-1:0] adc_data_b,
    // Frame clock from the downconverter, same clock domain
    input  wire logic                downconverter_frame_clock,
    // Toward the bit mapper
    output logic                     out_valid,
    input  wire logic                out_ready,
    output logic [SAMPLE_W-1:0]      out_data_a,
    output logic [SAMPLE_W-1:0]      out_data_b,
    output logic                     frame_clock
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic sclk_s1, sclk_s2, sclk_s3;
    logic sen_s1, sen_s2;
    logic sdin_s1, sdin_s2;
    logic sclk_rise, sclk_fall;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sclk_s1 <= 1'b0;
            sclk_s2 <= 1'b0;
            sclk_s3 <= 1'b0;
            sen_s1  <= 1'b1;
            sen_s2  <= 1'b1;
            sdin_s1 <= 1'b0;
            sdin_s2 <= 1'b0;
        end else begin
            sclk_s1 <= spi_sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sen_s1  <= spi_sen_n;
            sen_s2  <= sen_s1;
            sdin_s1 <= spi_sdin;
            sdin_s2 <= sdin_s1;
        end
    end

    assign sclk_rise = sclk_s2 && !sclk_s3;
    assign sclk_fall = !sclk_s2 && sclk_s3;

    // ****************************************************************
    // Serial control frame and registers
    // ****************************************************************
    tpf_spi_e              spi_state, next_spi_state;
    logic [4:0]            bit_cnt, next_bit_cnt;
    logic [SPI_ADDR_W:0]   cmd_shift, next_cmd_shift;
    logic [SPI_DATA_W-1:0] data_shift, next_data_shift;
    logic [SPI_DATA_W-1:0] rd_shift, next_rd_shift;
    logic                  next_sdout, next_sdout_oe;
    logic [7:0]            custom_pattern_low, next_custom_pattern_low;
    logic [7:0]            custom_pattern_mid, next_custom_pattern_mid;
    logic [7:0]            pattern_select_and_custom_high;
    logic [7:0]            next_pattern_select_and_custom_high;
    logic [7:0]            frame_clock_config, next_frame_clock_config;
    logic [7:0]            rd_value;
    logic [7:0]            wr_value;
    logic                  is_read;

    assign is_read  = cmd_shift[SPI_ADDR_W];
    assign wr_value = {data_shift[SPI_DATA_W-2:0], sdin_s2};

    // Unmapped addresses read as zero; reserved bits read as zero
    always_comb begin
        case (cmd_shift[SPI_ADDR_W-1:0])
            ADDR_CUSTOM_PATTERN_LOW:  rd_value = custom_pattern_low;
            ADDR_CUSTOM_PATTERN_MID:  rd_value = custom_pattern_mid;
            ADDR_PATTERN_SELECT_HIGH: rd_value =
                pattern_select_and_custom_high;
            ADDR_FRAME_CLOCK_CONFIG:  rd_value = frame_clock_config;
            default:                  rd_value = REG_UNMAPPED;
        endcase
    end

    always_comb begin
        next_spi_state  = spi_state;
        next_bit_cnt    = bit_cnt;
        next_cmd_shift  = cmd_shift;
        next_data_shift = data_shift;
        next_rd_shift   = rd_shift;
        next_sdout      = spi_sdout;
        next_sdout_oe   = spi_sdout_oe;
        next_custom_pattern_low = custom_pattern_low;
        next_custom_pattern_mid = custom_pattern_mid;
        next_pattern_select_and_custom_high =
            pattern_select_and_custom_high;
        next_frame_clock_config = frame_clock_config;
        if (sen_s2) begin
            // Deselect aborts any partial frame; no write happens
            next_spi_state = TPF_SPI_IDLE;
            next_bit_cnt   = SPI_CNT_ZERO;
            next_sdout_oe  = 1'b0;
            next_sdout     = 1'b0;
        end else begin
            case (spi_state)
                TPF_SPI_IDLE: begin
                    next_spi_state = TPF_SPI_CMD;
                    next_bit_cnt   = SPI_CNT_ZERO;
                end
                TPF_SPI_CMD: begin
                    if (sclk_rise) begin
                        next_cmd_shift = {cmd_shift[SPI_ADDR_W-1:0],
                                          sdin_s2};
                        next_bit_cnt   = bit_cnt + SPI_CNT_ONE;
                        if (bit_cnt == SPI_CMD_LAST) begin
                            next_spi_state = TPF_SPI_DATA;
                        end
                    end
                end
                TPF_SPI_DATA: begin
                    if (sclk_fall && is_read) begin
                        // Read data is launched on falling edges
                        next_sdout_oe = 1'b1;
                        if (!spi_sdout_oe) begin
                            next_sdout    = rd_value[SPI_DATA_W-1];
                            next_rd_shift = {rd_value[SPI_DATA_W-2:0],
                                             1'b0};
                        end else begin
                            next_sdout    = rd_shift[SPI_DATA_W-1];
                            next_rd_shift = {rd_shift[SPI_DATA_W-2:0],
                                             1'b0};
                        end
                    end
                    if (sclk_rise) begin
                        next_data_shift = wr_value;
                        next_bit_cnt    = bit_cnt + SPI_CNT_ONE;
                        if (bit_cnt == SPI_DATA_LAST) begin
                            next_spi_state = TPF_SPI_CMD;
                            next_bit_cnt   = SPI_CNT_ZERO;
                            if (!is_read) begin
                                case (cmd_shift[SPI_ADDR_W-1:0])
                                    ADDR_CUSTOM_PATTERN_LOW:
                                        next_custom_pattern_low = wr_value;
                                    ADDR_CUSTOM_PATTERN_MID:
                                        next_custom_pattern_mid = wr_value;
                                    ADDR_PATTERN_SELECT_HIGH:
                                        next_pattern_select_and_custom_high
                                            = wr_value;
                                    ADDR_FRAME_CLOCK_CONFIG:
                                        next_frame_clock_config =
                                            wr_value & FC_WRITE_MASK;
                                    default: ;
                                endcase
                            end
                        end
                    end
                end
                default: next_spi_state = TPF_SPI_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            spi_state    <= TPF_SPI_IDLE;
            bit_cnt      <= SPI_CNT_ZERO;
            cmd_shift    <= '0;
            data_shift   <= '0;
            rd_shift     <= '0;
            spi_sdout    <= 1'b0;
            spi_sdout_oe <= 1'b0;
            custom_pattern_low             <= REG_RESET;
            custom_pattern_mid             <= REG_RESET;
            pattern_select_and_custom_high <= REG_RESET;
            frame_clock_config             <= REG_RESET;
        end else begin
            spi_state    <= next_spi_state;
            bit_cnt      <= next_bit_cnt;
            cmd_shift    <= next_cmd_shift;
            data_shift   <= next_data_shift;
            rd_shift     <= next_rd_shift;
            spi_sdout    <= next_sdout;
            spi_sdout_oe <= next_sdout_oe;
            custom_pattern_low             <= next_custom_pattern_low;
            custom_pattern_mid             <= next_custom_pattern_mid;
            pattern_select_and_custom_high <=
                next_pattern_select_and_custom_high;
            frame_clock_config             <= next_frame_clock_config;
        end
    end

    // ****************************************************************
    // Per-channel pattern generation
    // ****************************************************************
    logic [SAMPLE_W-1:0] custom_pattern_value;
    logic [2:0]          pat_sel  [CHAN_NUM];
    logic [SAMPLE_W-1:0] adc_in   [CHAN_NUM];
    logic [SAMPLE_W-1:0] chan_out [CHAN_NUM];
    logic                fifo_in_ready;
    logic                sample_take;

    assign custom_pattern_value = {
        pattern_select_and_custom_high[CUST_HIGH_MSB:0],
        custom_pattern_mid, custom_pattern_low};
    assign pat_sel[0] =
        pattern_select_and_custom_high[PSEL_A_MSB:PSEL_A_LSB];
    assign pat_sel[1] =
        pattern_select_and_custom_high[PSEL_B_MSB:PSEL_B_LSB];
    assign adc_in[0]   = adc_data_a;
    assign adc_in[1]   = adc_data_b;
    assign sample_take = adc_valid && fifo_in_ready;

    for (genvar ch = 0; ch < CHAN_NUM; ch++) begin : g_chan
        logic [SAMPLE_W-1:0] ramp, next_ramp;

        always_comb begin
            next_ramp = ramp;
            if (pat_sel[ch] != PAT_RAMP) begin
                next_ramp = RAMP_START;
            end else if (sample_take) begin
                // Plain 18-bit add wraps at full scale
                next_ramp = ramp + custom_pattern_value;
            end
        end

        always_ff @(posedge clk_sys) begin
            if (rst) begin
                ramp <= RAMP_START;
            end else begin
                ramp <= next_ramp;
            end
        end

        // Native 18-bit width, ahead of any format or mapper choice;
        // unused codes fall back to converter data
        always_comb begin
            case (pat_sel[ch])
                PAT_RAMP:  chan_out[ch] = ramp;
                PAT_CONST: chan_out[ch] = custom_pattern_value;
                default:   chan_out[ch] = adc_in[ch];
            endcase
        end
    end

    // ****************************************************************
    // Sample buffer and output stage with frame clock
    // ****************************************************************
    logic                fifo_out_valid;
    logic [PAIR_W-1:0]   fifo_out_data;
    logic                load_out;
    logic [2:0]          frame_cnt, next_frame_cnt;
    logic                next_frame_clock;
    logic                next_out_valid;
    logic [SAMPLE_W-1:0] next_out_a, next_out_b;
    logic [1:0]          frame_span;

    tpf_sample_fifo #(
        .WIDTH (PAIR_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .in_valid  (adc_valid),
        .in_ready  (fifo_in_ready),
        .in_data   ({chan_out[1], chan_out[0]}),
        .out_valid (fifo_out_valid),
        .out_ready (load_out),
        .out_data  (fifo_out_data)
    );

    assign adc_ready = fifo_in_ready;
    assign load_out  = fifo_out_valid && (!out_valid || out_ready);
    // Each of halve and stretch doubles the frame length
    assign frame_span =
        {1'b0, frame_clock_config[FC_HALVE_BIT]} +
        {1'b0, frame_clock_config[FC_STRETCH_BIT]};

    always_comb begin
        next_out_valid   = out_valid;
        next_out_a       = out_data_a;
        next_out_b       = out_data_b;
        next_frame_cnt   = frame_cnt;
        next_frame_clock = frame_clock;
        if (load_out) begin
            next_out_valid = 1'b1;
            next_out_a     = fifo_out_data[SAMPLE_W-1:0];
            next_out_b     = fifo_out_data[PAIR_W-1:SAMPLE_W];
            next_frame_cnt = frame_cnt + FRAME_CNT_ONE;
            if (frame_clock_config[FC_SOURCE_BIT]) begin
                next_frame_clock = downconverter_frame_clock;
            end else begin
                next_frame_clock = next_frame_cnt[frame_span];
            end
        end else if (out_ready) begin
            next_out_valid = 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            out_valid   <= 1'b0;
            out_data_a  <= '0;
            out_data_b  <= '0;
            frame_cnt   <= '0;
            frame_clock <= 1'b0;
        end else begin
            out_valid   <= next_out_valid;
            out_data_a  <= next_out_a;
            out_data_b  <= next_out_b;
            frame_cnt   <= next_frame_cnt;
            frame_clock <= next_frame_clock;
        end
    end

endmodule : tpf_test_pattern_frame_clock

// *** rtl/tpf_pkg.sv ***
// Package for the test pattern and frame clock configuration block.
// Assumes an 18-bit converter core and a 24-bit serial control frame.
package tpf_pkg;

    // ****************************************************************
    // Sample path
    // ****************************************************************
    localparam int SAMPLE_W   = 18;
    localparam int PAIR_W     = 2 * SAMPLE_W;
    localparam int FIFO_DEPTH = 8;
    localparam int CHAN_NUM   = 2;

    // ****************************************************************
    // Serial control frame: R/W bit, 15 address bits, 8 data bits
    // ****************************************************************
    localparam int         SPI_ADDR_W    = 15;
    localparam int         SPI_DATA_W    = 8;
    localparam logic [4:0] SPI_CMD_LAST  = 5'h0f;
    localparam logic [4:0] SPI_DATA_LAST = 5'h17;
    localparam logic [4:0] SPI_CNT_ONE   = 5'h01;
    localparam logic [4:0] SPI_CNT_ZERO  = 5'h00;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam logic [SPI_ADDR_W-1:0] ADDR_CUSTOM_PATTERN_LOW  = 15'h0014;
    localparam logic [SPI_ADDR_W-1:0] ADDR_CUSTOM_PATTERN_MID  = 15'h0015;
    localparam logic [SPI_ADDR_W-1:0] ADDR_PATTERN_SELECT_HIGH = 15'h0016;
    localparam logic [SPI_ADDR_W-1:0] ADDR_FRAME_CLOCK_CONFIG  = 15'h0019;
    localparam logic [7:0]            REG_RESET                = 8'h00;
    localparam logic [7:0]            REG_UNMAPPED             = 8'h00;

    // Fields of the upper pattern register
    localparam int PSEL_B_MSB     = 7;
    localparam int PSEL_B_LSB     = 5;
    localparam int PSEL_A_MSB     = 4;
    localparam int PSEL_A_LSB     = 2;
    localparam int CUST_HIGH_MSB  = 1;

    // Fields of the frame clock register
    localparam int FC_SOURCE_BIT  = 7;
    localparam int FC_HALVE_BIT   = 4;
    localparam int FC_STRETCH_BIT = 0;
    localparam logic [7:0] FC_WRITE_MASK = 8'h91;

    // Pattern selector codes
    localparam logic [2:0] PAT_NORMAL = 3'h0;
    localparam logic [2:0] PAT_RAMP   = 3'h2;
    localparam logic [2:0] PAT_CONST  = 3'h3;

    localparam logic [SAMPLE_W-1:0] RAMP_START = 18'h00000;
    localparam logic [2:0]          FRAME_CNT_ONE = 3'h1;

    typedef enum logic [1:0] {
        TPF_SPI_IDLE,
        TPF_SPI_CMD,
        TPF_SPI_DATA
    } tpf_spi_e;

endpackage : tpf_pkg

// *** rtl/tpf_sample_fifo.sv ***
// Sample FIFO with valid/ready on both sides.
// Assumes a single clock and a power-of-two depth.
`timescale 1ns/10ps
module tpf_sample_fifo
    import tpf_pkg::*;
#(
    parameter int WIDTH = PAIR_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [PTR_W:0] CNT_FULL = PTR_W'(0) + (PTR_W+1)'(DEPTH);
    localparam logic [PTR_W:0] CNT_ZERO = '0;
    localparam logic [PTR_W-1:0] PTR_ONE = PTR_W'(1);
    localparam logic [PTR_W:0] CNT_ONE = (PTR_W+1)'(1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr, next_wr_ptr;
    logic [PTR_W-1:0] rd_ptr, next_rd_ptr;
    logic [PTR_W:0]   count, next_count;
    logic             next_in_ready, next_out_valid;
    logic             push, pop;

    assign push     = in_valid && in_ready;
    assign pop      = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_comb begin
        next_wr_ptr = push ? wr_ptr + PTR_ONE : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + PTR_ONE : rd_ptr;
        next_count  = count;
        if (push && !pop) begin
            next_count = count + CNT_ONE;
        end else if (pop && !push) begin
            next_count = count - CNT_ONE;
        end
        // Flags are registered so both ready and valid leave a flop
        next_in_ready  = (next_count != CNT_FULL);
        next_out_valid = (next_count != CNT_ZERO);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            count     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            wr_ptr    <= next_wr_ptr;
            rd_ptr    <= next_rd_ptr;
            count     <= next_count;
            in_ready  <= next_in_ready;
            out_valid <= next_out_valid;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : tpf_sample_fifo

// *** dv/tpf_props.sv ***
// Port timing checker for the test pattern and frame clock block.
// Bound to tpf_test_pattern_frame_clock below; sees only its ports.
`timescale 1ns/10ps
module tpf_props
    import tpf_pkg::*;
(
    input wire logic                clk_sys,
    input wire logic                rst,
    input wire logic                spi_sen_n,
    input wire logic                spi_sdout_oe,
    input wire logic                adc_valid,
    input wire logic                adc_ready,
    input wire logic                out_valid,
    input wire logic                out_ready,
    input wire logic [SAMPLE_W-1:0] out_data_a,
    input wire logic [SAMPLE_W-1:0] out_data_b,
    input wire logic                frame_clock
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (rst);
    a_reset_quiet: assert property (disable iff (1'b0)
        rst |=> !out_valid && !adc_ready && !frame_clock && !spi_sdout_oe)
        else $error("outputs not quiet after reset");
    a_ready_release: assert property (
        $fell(rst) |-> !adc_ready ##[1:2] adc_ready)
        else $error("sample port not ready after reset");
    a_data_hold: assert property (
        out_valid && !out_ready |=> $stable(out_data_a) && $stable(out_data_b))
        else $error("output pair changed while stalled");
    a_valid_hold: assert property (
        out_valid && !out_ready |=> out_valid)
        else $error("output valid dropped while stalled");
    a_frame_hold: assert property (
        out_valid && !out_ready |=> $stable(frame_clock))
        else $error("frame clock moved without a new pair");
    a_pair_arrives: assert property (
        adc_valid && adc_ready && !out_valid |-> ##[1:4] out_valid)
        else $error("accepted sample did not reach the output");
    a_oe_release: assert property (
        $rose(spi_sen_n) |-> ##[1:6] !spi_sdout_oe)
        else $error("read driver kept on after frame end");
    a_oe_idle: assert property (
        spi_sen_n [*8] |-> !spi_sdout_oe)
        else $error("read driver on outside a frame");
endmodule : tpf_props

bind tpf_test_pattern_frame_clock tpf_props u_props (
    .clk_sys(clk_sys), .rst(rst), .spi_sen_n(spi_sen_n),
    .spi_sdout_oe(spi_sdout_oe), .adc_valid(adc_valid),
    .adc_ready(adc_ready), .out_valid(out_valid), .out_ready(out_ready),
    .out_data_a(out_data_a), .out_data_b(out_data_b),
    .frame_clock(frame_clock)
);

// *** dv/tpf_host_sink.sv ***
// Host side capture logic: accepts output pairs with random stalls.
// Assumes the bench compares the pairs; stall holds ready low.
`timescale 1ns/10ps
module tpf_host_sink (
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic stall,
    output logic      out_ready
);
    int seed = 10;
    // Ready drops one cycle in four so held outputs get exercised
    always @(negedge clk_sys) begin
        out_ready <= !rst && !stall && (($random(seed) & 3) != 0);
    end
endmodule : tpf_host_sink

// *** dv/tb_tpf_test_pattern_frame_clock.sv ***
// Self-checking bench for the test pattern and frame clock block.
// Assumes the design files of rtl/ and the host sink model.
`timescale 1ns/10ps
module tb_tpf_test_pattern_frame_clock
    import tpf_pkg::*;
;
    logic                clk_sys = 0, rst = 1, sclk = 0, sen_n = 1;
    logic                sdin = 0, sdout, sdout_oe, adc_valid = 0, adc_ready;
    logic                dnc_fc = 0, out_valid, out_ready, fc, stall = 0;
    logic                took = 0;
    logic [SAMPLE_W-1:0] da = 18'h00000, db = 18'h00000, oa, ob, cust;
    logic [SAMPLE_W-1:0] ramp_a, ramp_b;
    logic [2:0]          sel_a, sel_b;
    logic [PAIR_W-1:0]   expq[$];
    logic                fcq[$];
    int                  err_total = 0, checked = 0, seed = 10, n;
    logic [14:0]         regs[5] = '{15'h0014, 15'h0015, 15'h0016,
                                     15'h0019, 15'h0017};
    logic [17:0]         steps[4] = '{18'h00001, 18'h00004, 18'h00010,
                                      18'h3ffff};
    always #2 clk_sys = ~clk_sys;
    always @(negedge clk_sys) dnc_fc <= 1'($random(seed));

    tpf_test_pattern_frame_clock DUT (
        .clk_sys(clk_sys), .rst(rst), .spi_sclk(sclk), .spi_sen_n(sen_n),
        .spi_sdin(sdin), .spi_sdout(sdout), .spi_sdout_oe(sdout_oe),
        .adc_valid(adc_valid), .adc_ready(adc_ready), .adc_data_a(da),
        .adc_data_b(db), .downconverter_frame_clock(dnc_fc),
        .out_valid(out_valid), .out_ready(out_ready), .out_data_a(oa),
        .out_data_b(ob), .frame_clock(fc)
    );
    tpf_host_sink u_sink (
        .clk_sys(clk_sys), .rst(rst), .stall(stall), .out_ready(out_ready)
    );

    // ****************************************************************
    // Checking helpers
    // ****************************************************************
    task automatic check(string what, logic [35:0] seen, logic [35:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim

    function automatic logic [17:0] pick(logic [2:0] s, logic [17:0] d, r);
        return (s == PAT_CONST) ? cust : (s == PAT_RAMP) ? r : d;
    endfunction : pick

    // Expected pair is fixed at the edge where the sample is taken
    always @(posedge clk_sys) begin
        if (!rst && adc_valid && adc_ready) begin
            expq.push_back({pick(sel_b, db, ramp_b), pick(sel_a, da, ramp_a)});
            ramp_a = (sel_a == PAT_RAMP) ? ramp_a + cust : RAMP_START;
            ramp_b = (sel_b == PAT_RAMP) ? ramp_b + cust : RAMP_START;
            took = 1;
        end
        if (!rst && out_valid && out_ready) begin
            check("out_pair", {ob, oa}, expq.pop_front());
            fcq.push_back(fc);
        end
    end

    // ****************************************************************
    // Serial control port: 24-bit frames, bits change while sclk low
    // ****************************************************************
    task automatic spi(logic rd, logic [14:0] adr, logic [7:0] wd,
                       output logic [7:0] q);
        logic [23:0] w;
        w = {rd, adr, wd};
        sen_n = 0;
        repeat (3) @(negedge clk_sys);
        for (int i = 23; i >= 0; i--) begin
            sclk = 0;
            sdin = w[i];
            repeat (4) @(negedge clk_sys);
            if (i < 8)
                q[i] = sdout;
            sclk = 1;
            repeat (4) @(negedge clk_sys);
        end
        sclk = 0;
        sdin = ~sdin;
        repeat (4) @(negedge clk_sys);
        sen_n = 1;
        repeat (6) @(negedge clk_sys);
    endtask : spi

    task automatic wr(logic [14:0] a, logic [7:0] d);
        logic [7:0] q;
        spi(1'b0, a, d, q);
    endtask : wr

    task automatic rdchk(logic [14:0] a, logic [7:0] e);
        logic [7:0] q;
        spi(1'b1, a, 8'h00, q);
        check("reg_read", 36'(q), 36'(e));
    endtask : rdchk

    // Selector cleared first so both ramps restart from zero
    task automatic cfg(logic [2:0] sa, sb, logic [17:0] cu, logic [7:0] f);
        wr(ADDR_PATTERN_SELECT_HIGH, 8'h00);
        wr(ADDR_FRAME_CLOCK_CONFIG, f);
        wr(ADDR_CUSTOM_PATTERN_LOW, cu[7:0]);
        wr(ADDR_CUSTOM_PATTERN_MID, cu[15:8]);
        wr(ADDR_PATTERN_SELECT_HIGH, {sb, sa, cu[17:16]});
        sel_a = sa;
        sel_b = sb;
        cust = cu;
        ramp_a = RAMP_START;
        ramp_b = RAMP_START;
    endtask : cfg

    // ****************************************************************
    // Sample stream: p is the frame clock half period in pairs
    // ****************************************************************
    task automatic run(int cnt, int p);
        fcq.delete();
        for (int i = 0; i < cnt; i++) begin
            adc_valid = 1;
            da = 18'($random(seed));
            db = 18'($random(seed));
            took = 0;
            for (int t = 0; t < 200 && !took; t++)
                @(negedge clk_sys);
            check("taken", 36'(took), 36'h1);
            adc_valid = 1'($random(seed));
            if (!adc_valid)
                @(negedge clk_sys);
        end
        adc_valid = 0;
        for (int t = 0; t < 400 && expq.size() != 0; t++)
            @(negedge clk_sys);
        check("drained", 36'(expq.size()), 36'h0);
        for (int i = p; i < fcq.size() && p > 0; i++)
            check("frame_clock", 36'(fcq[i]), 36'(!fcq[i - p]));
    endtask : run

    initial begin
        repeat (12) @(negedge clk_sys);
        rst = 0;
        repeat (4) @(negedge clk_sys);
        foreach (regs[i])
            rdchk(regs[i], REG_RESET);
        wr(ADDR_FRAME_CLOCK_CONFIG, 8'hff);
        rdchk(ADDR_FRAME_CLOCK_CONFIG, FC_WRITE_MASK);
        $display("test register reset and access done");
        for (int c = 0; c < 8; c++) begin
            cfg(3'(c), 3'(7 - c), 18'($random(seed)), 8'h00);
            rdchk(ADDR_PATTERN_SELECT_HIGH,
                  {3'(7 - c), 3'(c), cust[17:16]});
            run(12, 1);
        end
        $display("test selector codes done");
        foreach (steps[i]) begin
            cfg(PAT_RAMP, PAT_RAMP, steps[i], 8'h00);
            run(20, 1);
        end
        $display("test ramp steps done");
        cfg(PAT_NORMAL, PAT_CONST, 18'h2a5c3, 8'h10);
        run(16, 2);
        cfg(PAT_CONST, PAT_NORMAL, 18'h1035a, 8'h01);
        run(16, 2);
        cfg(PAT_NORMAL, PAT_NORMAL, 18'h00000, 8'h80);
        run(16, 0);
        $display("test frame clock modes done");
        stall = 1;
        n = 0;
        adc_valid = 1;
        took = 0;
        for (int t = 0; t < 40; t++) begin
            @(negedge clk_sys);
            n += took;
            took = 0;
        end
        check("fill_count", 36'(n), 36'h9);
        stall = 0;
        run(1, 0);
        $display("test buffer fill and drain done");
        end_sim();
    end

    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : tb_tpf_test_pattern_frame_clock
